// >>> dpra_host_ctrl.sv
/*
  host-side controller for one port of an asynchronous dual-port ram with
  mailboxes, busy arbitration and token latches. one request at a time.
  assumes all pin inputs synchronous to core_clk; data pin resolved outside.
*/
`include "dpra_params.svh"
module dpra_host_ctrl
  import dpra_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    reqValid,
  input  wire logic                    reqWrite,
  input  wire logic                    reqToken,
  input  wire logic [`DPRA_ADDR_W-1:0] reqAddr,
  input  wire logic [`DPRA_DATA_W-1:0] reqData,
  output logic                         reqReady,
  output logic                         rspValid,
  output logic [`DPRA_DATA_W-1:0]      rspData,
  output logic                         rspBusy,
  input  wire logic                    slaveMode,
  input  wire logic                    msgPassEn,
  output logic                         intReq,
  output logic                         memSelN,
  output logic                         token_latch_select_n,
  output logic                         rwN,
  output logic                         oeN,
  output logic [`DPRA_ADDR_W-1:0]      pinAddr,
  output logic [`DPRA_DATA_W-1:0]      pinDataOut,
  output logic                         pinDataOe,
  input  wire logic [`DPRA_DATA_W-1:0] pinDataIn,
  input  wire logic                    busyN,
  input  wire logic                    intN
);
  dpra_state_type                state_r;
  dpra_state_type                state_nxt;
  logic                          wr_r;
  logic                          tok_r;
  logic [`DPRA_ADDR_W-1:0]       addr_r;
  logic [`DPRA_DATA_W-1:0]       data_r;
  logic                          tmrDone;
  logic                          tmrLoad;
  logic [`DPRA_CNT_W-1:0]        tmrVal;
  logic                          accept;
  logic                          selActNxt;
  logic                          strobeNxt;
  logic                          readEnd;
  logic [`DPRA_ADDR_W-1:0]       pinAddrNxt;
  logic                          selLow;

  assign accept = (state_r == DPRA_IDLE) && reqValid;
  assign readEnd = (state_r == DPRA_STROBE) && tmrDone && !wr_r;

  // phase sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DPRA_IDLE:   if (reqValid) state_nxt = DPRA_ADDR;
      DPRA_ADDR:   state_nxt = DPRA_SEL;
      DPRA_SEL: begin
        if (tmrDone) begin
          if (wr_r && !busyN) state_nxt = DPRA_WAITB;
          else                state_nxt = DPRA_STROBE;
        end
      end
      DPRA_WAITB:  if (busyN) state_nxt = DPRA_STROBE;
      DPRA_STROBE: if (tmrDone) state_nxt = DPRA_HOLD;
      DPRA_HOLD:   state_nxt = DPRA_RECOV;
      DPRA_RECOV:  if (tmrDone) state_nxt = DPRA_IDLE;
      default:     state_nxt = DPRA_IDLE;
    endcase
  end

  assign tmrLoad = (state_nxt != state_r) &&
                   (state_nxt == DPRA_SEL || state_nxt == DPRA_STROBE ||
                    state_nxt == DPRA_RECOV);

  // phase lengths
  assign tmrVal = (state_nxt == DPRA_SEL)    ? `DPRA_CNT_W'(`DPRA_SETTLE_CYC) :
                  (state_nxt == DPRA_STROBE) ?
                    (wr_r ? `DPRA_CNT_W'(`DPRA_WSTROBE_CYC) : `DPRA_CNT_W'(`DPRA_RSTROBE_CYC)) :
                  (tok_r && wr_r) ? `DPRA_CNT_W'(`DPRA_FLAG_PULSE_CYC) :
                  `DPRA_CNT_W'(`DPRA_RECOV_CYC);

  dpra_cycle_timer u_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .load     (tmrLoad),
    .loadVal  (tmrVal),
    .done     (tmrDone)
  );

  // pin values follow the next phase so every pin leaves a flip-flop
  assign selActNxt = (state_nxt == DPRA_SEL) || (state_nxt == DPRA_WAITB) ||
                     (state_nxt == DPRA_STROBE) || (state_nxt == DPRA_HOLD);
  assign strobeNxt = (state_nxt == DPRA_STROBE);
  // address is launched at accept, a cycle ahead of any select
  assign pinAddrNxt = reqToken ? {{(`DPRA_ADDR_W-`DPRA_TOKEN_ADDR_W){1'b0}},
                                  reqAddr[`DPRA_TOKEN_ADDR_W-1:0]} : reqAddr;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= DPRA_IDLE;
      wr_r    <= 1'b0;
      tok_r   <= 1'b0;
      addr_r  <= `DPRA_ADDR_W'(0);
      data_r  <= `DPRA_DATA_W'(0);
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        wr_r   <= reqWrite;
        tok_r  <= reqToken;
        addr_r <= reqAddr;
        data_r <= reqData;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      memSelN              <= 1'b1;
      token_latch_select_n <= 1'b1;
      rwN                  <= 1'b1;
      oeN                  <= 1'b1;
      pinDataOe            <= 1'b0;
      pinDataOut           <= `DPRA_DATA_W'(0);
      pinAddr              <= `DPRA_ADDR_W'(0);
    end else begin
      memSelN              <= !(selActNxt && !tok_r);
      token_latch_select_n <= !(selActNxt && tok_r);
      rwN                  <= !(strobeNxt && wr_r);
      oeN                  <= !(strobeNxt && !wr_r);
      pinDataOe            <= wr_r && (strobeNxt || state_nxt == DPRA_HOLD);
      pinDataOut           <= data_r;
      if (accept) pinAddr <= pinAddrNxt;
    end
  end

  // user side answer and interrupt gate
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqReady <= 1'b1;
      rspValid <= 1'b0;
      rspData  <= `DPRA_DATA_W'(0);
      rspBusy  <= 1'b0;
      intReq   <= 1'b0;
    end else begin
      reqReady <= (state_nxt == DPRA_IDLE);
      rspValid <= (state_r == DPRA_RECOV) && tmrDone;
      if (readEnd) begin
        rspData <= pinDataIn;
        rspBusy <= !busyN;
      end else if (accept) begin
        rspBusy <= 1'b0;
      end
      intReq <= msgPassEn && !intN;
    end
  end

  assign selLow = !memSelN || !token_latch_select_n;

  default clocking dpraCk @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence writeStrobeEnd;
    $rose(rwN);
  endsequence

  sequence selectThenStrobe;
    !memSelN || !token_latch_select_n;
  endsequence

  AST_SETUP_HELD: assert property (writeStrobeEnd |-> pinDataOe && $stable(pinDataOut))
    else $error("write data not held to strobe end");

  AST_STROBE_ENDS_FIRST: assert property (writeStrobeEnd |-> selectThenStrobe ##1 !rwN == 1'b0)
    else $error("select rose before write strobe");

  AST_TOKEN_SEL_EXCL: assert property (!token_latch_select_n |-> memSelN)
    else $error("memory select low during token access");

  AST_TOKEN_ADDR_LOW: assert property (!token_latch_select_n |->
      pinAddr[`DPRA_ADDR_W-1:`DPRA_TOKEN_ADDR_W] == '0)
    else $error("token access with upper address bits set");

  AST_BUSY_SETTLED: assert property ($fell(rwN) |-> busyN && $past(selLow, 1))
    else $error("write strobe during busy or before settle");

  AST_FLAG_PULSE: assert property ($rose(token_latch_select_n) && wr_r |->
      token_latch_select_n ##1 token_latch_select_n)
    else $error("token reselected before flag update pulse");

  AST_ADDR_QUIET: assert property (!$stable(pinAddr) |-> rwN && memSelN && token_latch_select_n)
    else $error("address moved under active strobe");

  AST_INT_GATED: assert property (!msgPassEn |=> !intReq)
    else $error("interrupt passed while message passing off");

endmodule // dpra_host_ctrl

// >>> dpra_params.svh
/*
  constants for the dual-port ram host controller: timings, address fields, state codes.
  assumes a 40 MHz core clock; included by bare name.
*/
// Contract
// - Writer holds data stable for the setup time before write strobe rises.
// - Write ends on whichever of write strobe or port select rises first.
// - Without message passing, leave the interrupt off the processor's request input.
// - Slave's controller delays its write until busy has settled.
// - Token access: token select low, memory select high, address bits 0-2 only.
// - After a token write, deselect for the flag update pulse before reading back.
// - Write strobe or port select stays high whenever address lines change.
`ifndef DPRA_PARAMS_SVH
`define DPRA_PARAMS_SVH

`define DPRA_CLK_PERIOD_NS   25
`define DPRA_CEIL_CYC(ns)    ((((ns) + `DPRA_CLK_PERIOD_NS - 1) / `DPRA_CLK_PERIOD_NS))

`define DPRA_ADDR_W          14
`define DPRA_DATA_W          8
`define DPRA_TOKEN_ADDR_W    3
`define DPRA_CNT_W           4

`define DPRA_WRITE_SETUP_NS  15
`define DPRA_WRITE_PULSE_NS  15
`define DPRA_READ_ACCESS_NS  20
`define DPRA_MATCH_FLAG_NS   20
`define DPRA_SELECT_FLAG_NS  20
`define DPRA_FLAG_PULSE_NS   10

`define DPRA_SETTLE_CYC      `DPRA_CEIL_CYC(`DPRA_SELECT_FLAG_NS)
`define DPRA_WSTROBE_CYC     `DPRA_CEIL_CYC(`DPRA_WRITE_PULSE_NS)
`define DPRA_RSTROBE_CYC     `DPRA_CEIL_CYC(`DPRA_READ_ACCESS_NS)
`define DPRA_FLAG_PULSE_CYC  `DPRA_CEIL_CYC(`DPRA_FLAG_PULSE_NS)
`define DPRA_RECOV_CYC       1

`define DPRA_ST_IDLE         3'h0
`define DPRA_ST_ADDR         3'h1
`define DPRA_ST_SEL          3'h2
`define DPRA_ST_WAITB        3'h3
`define DPRA_ST_STROBE       3'h4
`define DPRA_ST_HOLD         3'h5
`define DPRA_ST_RECOV        3'h6

`endif

// >>> dpra_pkg.sv
/*
  types for the dual-port ram host controller.
  assumes dpra_params.svh is on the include path.
*/
`include "dpra_params.svh"
package dpra_pkg;
  typedef enum logic [2:0] {
    DPRA_IDLE   = `DPRA_ST_IDLE,
    DPRA_ADDR   = `DPRA_ST_ADDR,
    DPRA_SEL    = `DPRA_ST_SEL,
    DPRA_WAITB  = `DPRA_ST_WAITB,
    DPRA_STROBE = `DPRA_ST_STROBE,
    DPRA_HOLD   = `DPRA_ST_HOLD,
    DPRA_RECOV  = `DPRA_ST_RECOV
  } dpra_state_type;
endpackage : dpra_pkg

// >>> dpra_cycle_timer.sv
/*
  down counter for phase lengths; done is high in the last cycle of a phase.
  assumes load lands in the first cycle edge of the phase.
*/
`include "dpra_params.svh"
module dpra_cycle_timer
  import dpra_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic                   load,
  input  wire logic [`DPRA_CNT_W-1:0] loadVal,
  output logic                        done
);
  logic [`DPRA_CNT_W-1:0] cnt_r;
  logic [`DPRA_CNT_W-1:0] cnt_nxt;

  assign done = (cnt_r <= `DPRA_CNT_W'(1));
  assign cnt_nxt = load ? loadVal : (done ? cnt_r : cnt_r - `DPRA_CNT_W'(1));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) cnt_r <= `DPRA_CNT_W'(0);
    else        cnt_r <= cnt_nxt;
  end
endmodule // dpra_cycle_timer

// >>> dpra_dev_model.sv
/*
  behavioural model of one port of the dual-port ram: array, mailbox flag, busy, token latches.
  assumes one host controller on the pins; the peer port is emulated by bench inputs.
*/
module dpra_dev_model (
  input  wire logic        memSelN,
  input  wire logic        token_latch_select_n,
  input  wire logic        rwN,
  input  wire logic        oeN,
  input  wire logic [13:0] pinAddr,
  input  wire logic [7:0]  pinDataOut,
  input  wire logic        peerMail,
  input  wire logic        peerHold,
  input  wire logic        busyIn,
  output logic [7:0]       devData,
  output logic             intN,
  output logic             busyN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:16383];
  logic [7:0] mine;
  logic [7:0] pend;
  logic [7:0] q;
  logic       intFlag;
  logic       isTok;
  logic       peerFlag;
  wire        anySel = !memSelN || !token_latch_select_n;
  wire        wrOn   = !rwN && anySel;
  wire        rdOn   = !oeN && rwN && anySel;
  initial begin
    intFlag = 1'b0;
    peerFlag = 1'b0;
    isTok = 1'b0;
    mine = 8'h00;
    pend = 8'h00;
    q = 8'h00;
  end
  // busyIn high: this port lost arbitration to the peer
  assign busyN = !busyIn;
  assign intN = !intFlag;
  // released bus shows the inverse of the last value
  assign devData = rdOn ? q : ~q;
  always @(posedge wrOn) isTok = !token_latch_select_n;
  // write lands when strobe or select ends it
  always @(negedge wrOn) begin
    if (!isTok) begin
      mem[pinAddr] = pinDataOut;
      if (pinAddr == 14'h3fff && !busyIn)
        peerFlag = 1'b1;
    end else if (pinDataOut[0]) begin
      mine[pinAddr[2:0]] = 1'b0;
      pend[pinAddr[2:0]] = 1'b0;
    end else if (peerHold)
      pend[pinAddr[2:0]] = 1'b1;
    else
      mine[pinAddr[2:0]] = 1'b1;
  end
  always @(negedge peerHold) begin
    mine = mine | pend;
    pend = 8'h00;
  end
  always @(negedge oeN) begin
    if (!token_latch_select_n)
      q = {8{!mine[pinAddr[2:0]]}};
    else
      q = mem[pinAddr]; // peer never writes this word mid-read
    if (!memSelN && pinAddr == 14'h3ffe && !busyIn)
      intFlag = 1'b0;
  end
  always @(posedge peerMail) intFlag = 1'b1;
endmodule // dpra_dev_model

// >>> dual_port_ram_arbitration_bench.sv
/*
  self-checking bench for the dual-port ram host controller.
  assumes dpra_dev_model stands on the pins; peer activity is driven here.
*/
module dual_port_ram_arbitration_bench
  import dpra_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, rst_b, reqValid, reqWrite, reqToken, msgPassEn;
  logic        peerMail, peerHold, busyIn;
  logic [13:0] reqAddr;
  logic [7:0]  reqData;
  wire logic        reqReady, rspValid, rspBusy, intReq, memSelN, tokSelN;
  wire logic        rwN, oeN, pinDataOe, busyN, intN;
  wire logic [13:0] pinAddr;
  wire logic [7:0]  rspData, pinDataOut, devData;
  wire logic [7:0]  pinDataIn = pinDataOe ? pinDataOut : devData;
  int n_mismatch = 0;
  int compares = 0;
  int lat;

  dpra_host_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqToken(reqToken), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspBusy(rspBusy),
    .slaveMode(1'b1), .msgPassEn(msgPassEn), .intReq(intReq), .memSelN(memSelN),
    .token_latch_select_n(tokSelN), .rwN(rwN), .oeN(oeN), .pinAddr(pinAddr),
    .pinDataOut(pinDataOut), .pinDataOe(pinDataOe), .pinDataIn(pinDataIn),
    .busyN(busyN), .intN(intN));
  dpra_dev_model model (.memSelN(memSelN), .token_latch_select_n(tokSelN), .rwN(rwN),
    .oeN(oeN), .pinAddr(pinAddr), .pinDataOut(pinDataOut), .peerMail(peerMail),
    .peerHold(peerHold), .busyIn(busyIn), .devData(devData), .intN(intN), .busyN(busyN));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic req(input logic w, input logic t, input logic [13:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqToken <= t;
    reqAddr <= a;
    reqData <= d;
    @(posedge core_clk);
    reqValid <= 1'b0;
    lat = 0;
    do begin
      @(negedge core_clk);
      lat++;
    end while (rspValid !== 1'b1 && lat < 60);
  endtask

  task automatic t_mem;
    req(1'b1, 1'b0, 14'h0000, 8'h5a);
    chk(lat == 6, "write latency");
    req(1'b1, 1'b0, 14'h3fff, 8'ha5);
    chk(model.peerFlag === 1'b1, "peer mailbox flag");
    req(1'b0, 1'b0, 14'h0000, 8'h00);
    chk(rspData === 8'h5a, "read low");
    req(1'b0, 1'b0, 14'h3fff, 8'h00);
    chk(rspData === 8'ha5, "read top");
  endtask

  task automatic t_mail;
    @(posedge core_clk);
    peerMail <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk(intReq === 1'b1, "mail flag");
    req(1'b0, 1'b0, 14'h3fff, 8'h00);
    chk(intReq === 1'b1, "peer box read");
    req(1'b0, 1'b0, 14'h3ffe, 8'h00);
    repeat (2) @(negedge core_clk);
    chk(intReq === 1'b0, "flag clear");
    @(posedge core_clk);
    peerMail <= 1'b0;
    msgPassEn <= 1'b0;
    @(posedge core_clk);
    peerMail <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk(intReq === 1'b0, "masked flag");
    @(posedge core_clk);
    msgPassEn <= 1'b1;
    peerMail <= 1'b0;
    busyIn <= 1'b1;
    req(1'b0, 1'b0, 14'h3ffe, 8'h00);
    chk(rspBusy === 1'b1 && intReq === 1'b1, "busy box read");
    @(posedge core_clk);
    busyIn <= 1'b0;
    req(1'b0, 1'b0, 14'h3ffe, 8'h00);
    chk(rspBusy === 1'b0 && intReq === 1'b0, "free box read");
  endtask

  task automatic t_busy;
    @(posedge core_clk);
    busyIn <= 1'b1;
    fork
      req(1'b1, 1'b0, 14'h0100, 8'h3c);
      begin
        repeat (12) @(negedge core_clk);
        chk(rwN === 1'b1 && rspValid === 1'b0 && reqReady === 1'b0, "write under busy");
        @(posedge core_clk);
        busyIn <= 1'b0;
      end
    join
    chk(lat > 11 && lat < 20, "busy release");
    req(1'b0, 1'b0, 14'h0100, 8'h00);
    chk(rspData === 8'h3c, "busy write data");
  endtask

  task automatic t_token;
    req(1'b1, 1'b0, 14'h0003, 8'h77);
    req(1'b1, 1'b1, 14'h3ff3, 8'hfe);
    req(1'b0, 1'b1, 14'h0003, 8'h00);
    chk(rspData === 8'h00, "token taken");
    req(1'b1, 1'b1, 14'h0003, 8'h01);
    req(1'b0, 1'b1, 14'h0003, 8'h00);
    chk(rspData === 8'hff, "token freed");
    @(posedge core_clk);
    peerHold <= 1'b1;
    req(1'b1, 1'b1, 14'h0003, 8'h00);
    req(1'b0, 1'b1, 14'h0003, 8'h00);
    chk(rspData === 8'hff, "token held by peer");
    @(posedge core_clk);
    peerHold <= 1'b0;
    req(1'b0, 1'b1, 14'h0003, 8'h00);
    chk(rspData === 8'h00, "pending request won");
    req(1'b1, 1'b1, 14'h0003, 8'h01);
    req(1'b0, 1'b0, 14'h0003, 8'h00);
    chk(rspData === 8'h77, "array untouched");
  endtask

  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    {reqValid, reqWrite, reqToken, peerMail, peerHold, busyIn} = 6'h00;
    msgPassEn = 1'b1;
    reqAddr = 14'h0000;
    reqData = 8'h00;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    t_mem();
    t_mail();
    t_busy();
    t_token();
    test_done();
  end
endmodule // dual_port_ram_arbitration_bench
